/* design/ssq_pkg.sv */
// Shared constants and types of the servo alarm and overtravel sequencer
package ssq_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [7:0] OFS_MSW = 8'h00;
  localparam logic [7:0] OFS_TLIM = 8'h04;
  localparam logic [7:0] OFS_TRQ_LVL = 8'h08;
  localparam logic [7:0] OFS_SPD_LVL = 8'h0C;
  localparam logic [7:0] OFS_ACC_LVL = 8'h10;
  localparam logic [7:0] OFS_ERR_LVL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_CTRL = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN = 8'h28;

  // Reset values
  localparam logic [15:0] MSW_RESET = 16'h0080;
  localparam logic [15:0] TLIM_RESET = 16'h0000;
  localparam logic [15:0] TRQ_LVL_RESET = 16'h00C8;
  localparam logic [15:0] SPD_LVL_RESET = 16'h0000;
  localparam logic [15:0] ACC_LVL_RESET = 16'h0000;
  localparam logic [15:0] ERR_LVL_RESET = 16'h2710;
  localparam logic [3:0] IRQ_EN_RESET = 4'h0;

  // Memory-switch field positions
  localparam int MSW_MOTION_SEL = 4;
  localparam int MSW_AUTO_RESET = 5;
  localparam int MSW_COAST = 6;
  localparam int MSW_HOLD_BRAKE = 7;
  localparam int MSW_OT_DECEL = 8;
  localparam int MSW_OT_CLAMP = 9;
  localparam int MSW_KEEP_ERR = 10;
  localparam int MSW_MODE_OFF = 11;
  localparam int MSW_MODE_SEL_LO = 12;

  // Control register fields
  localparam int CTRL_ALARM_RESET = 0;

  // Interrupt status layout
  localparam int IRQ_W = 4;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_OT = 1;
  localparam int IRQ_AUTO_RST = 2;
  localparam int IRQ_MODE = 3;

  // Status register fields
  localparam int ST_STATE_LO = 0;
  localparam int ST_ALARM = 3;
  localparam int ST_BRAKE = 4;
  localparam int ST_SERVO = 5;
  localparam int ST_PCTRL = 6;
  localparam int ST_OT = 7;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_RUN = 3'h1,
    ST_OT_DECEL = 3'h3,
    ST_OT_CLAMP = 3'h2,
    ST_OT_OFF = 3'h6,
    ST_OT_STOP = 3'h7,
    ST_ALM_STOP = 3'h5,
    ST_ALM_HOLD = 3'h4
  } ssq_state_t;

  typedef enum logic [1:0] {
    COND_TORQUE = 2'h0,
    COND_SPEED = 2'h1,
    COND_ACCEL = 2'h2,
    COND_ERROR = 2'h3
  } ssq_mode_cond_t;

endpackage : ssq_pkg

/* design/ssq_mode_if.sv */
// Link between the sequencer and its mode-switch comparator
`timescale 1ns/100ps
interface ssq_mode_if #(
  parameter int W = 16
);
  import ssq_pkg::*;
  ssq_mode_cond_t sel;
  logic off;
  logic [W-1:0] torque_ref;
  logic [W-1:0] speed_ref;
  logic [W-1:0] accel;
  logic [W-1:0] err_count;
  logic [W-1:0] torque_lvl;
  logic [W-1:0] speed_lvl;
  logic [W-1:0] accel_lvl;
  logic [W-1:0] err_lvl;
  logic active;
  logic changed;

  modport ctrl (
    output sel, off, torque_ref, speed_ref, accel, err_count,
    output torque_lvl, speed_lvl, accel_lvl, err_lvl,
    input active, changed
  );
  modport sw (
    input sel, off, torque_ref, speed_ref, accel, err_count,
    input torque_lvl, speed_lvl, accel_lvl, err_lvl,
    output active, changed
  );
endinterface : ssq_mode_if

/* design/ssq_mode_switch.sv */
// Mode-switch comparator: selects a quantity and compares it with its level
`timescale 1ns/100ps
module ssq_mode_switch (
  input wire logic mclk_i,
  input wire logic srst_i,
  ssq_mode_if.sw mif
);
  import ssq_pkg::*;

  typedef struct packed {
    logic active;
    logic changed;
  } ssq_msw_state_t;

  ssq_msw_state_t q, d;
  logic [$bits(mif.torque_ref)-1:0] qty;
  logic [$bits(mif.torque_ref)-1:0] lvl;

  always_comb begin
    d = q;
    qty = mif.torque_ref;
    lvl = mif.torque_lvl;
    case (mif.sel) // [R9]
      COND_TORQUE: begin
        qty = mif.torque_ref;
        lvl = mif.torque_lvl;
      end
      COND_SPEED: begin
        qty = mif.speed_ref;
        lvl = mif.speed_lvl;
      end
      COND_ACCEL: begin
        qty = mif.accel;
        lvl = mif.accel_lvl;
      end
      COND_ERROR: begin
        qty = mif.err_count;
        lvl = mif.err_lvl;
      end
      default: begin
        qty = mif.torque_ref;
        lvl = mif.torque_lvl;
      end
    endcase
    // Equal to the level keeps the last decision, so no chatter at the threshold
    if (mif.off) begin
      d.active = 1'b0; // [R8]
    end else if (qty > lvl) begin
      d.active = 1'b1; // [R11]
    end else if (qty < lvl) begin
      d.active = 1'b0; // [R11]
    end
    d.changed = d.active != q.active;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign mif.active = q.active;
  assign mif.changed = q.changed;

endmodule : ssq_mode_switch

/* design/ssq_sequencer.sv */
// Servo alarm, overtravel and mode-switch sequencer with its register file
// Operation
// [R1] Bit 4 picks running (0) or torque-limit (1) indication on motion detect output.
// [R2] Bit 5 set clears the servo alarm automatically when power returns.
// [R3] Alarm stop uses dynamic brake when bit 6 is 0, coasting when 1.
// [R4] After alarm brake stop, bit 7 keeps brake applied; otherwise it releases.
// [R5] Overtravel stops per bit 6 when bit 8 is 0, torque-limited decel when 1.
// [R6] After torque-limited overtravel decel, bit 9 picks servo OFF or zero-clamp.
// [R7] Bit A at 0 clears error pulses whenever the servo turns OFF.
// [R8] Bit B at 1 disables the mode-switch function.
// [R9] Bits D,C select torque, speed, acceleration or error pulse as condition.
// [R10] Memory-switch bits 4 to D reset to 0, bit 7 to 1.
// [R11] Above its level the mode switch drops to proportional control; below it reverts.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module ssq_sequencer #(
  parameter int Q_W = 16
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [ssq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ssq_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ssq_pkg::DATA_W-1:0] rdata_o,
  input wire logic alarm_i,
  input wire logic power_loss_i,
  input wire logic servo_on_req_i,
  input wire logic forward_travel_limit_i,
  input wire logic reverse_travel_limit_i,
  input wire logic motor_running_i,
  input wire logic torque_limited_i,
  input wire logic motor_stopped_i,
  input wire logic [Q_W-1:0] torque_ref_i,
  input wire logic [Q_W-1:0] speed_ref_i,
  input wire logic [Q_W-1:0] accel_i,
  input wire logic [Q_W-1:0] err_count_i,
  output logic motion_detect_output_o,
  output logic servo_enable_o,
  output logic dyn_brake_o,
  output logic torque_decel_o,
  output logic [Q_W-1:0] torque_limit_setting_o,
  output logic zero_clamp_o,
  output logic clear_error_o,
  output logic p_control_o,
  output logic irq_o
);
  import ssq_pkg::*;

  typedef struct packed {
    ssq_state_t state;
    logic [DATA_W-1:0] msw;
    logic [Q_W-1:0] tlim;
    logic [Q_W-1:0] trq_lvl;
    logic [Q_W-1:0] spd_lvl;
    logic [Q_W-1:0] acc_lvl;
    logic [Q_W-1:0] err_lvl;
    logic alarm;
    logic alarm_in;
    logic power_lost;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [DATA_W-1:0] rdata;
    logic motion;
    logic servo;
    logic brake;
    logic decel;
    logic clamp;
    logic clr_err;
    logic pctrl;
    logic irq;
  } ssq_seq_state_t;

  ssq_seq_state_t q, d;
  ssq_mode_if #(.W(Q_W)) mif ();

  logic overtravel;
  logic alarm_rise;
  logic recovery;
  logic auto_reset;
  logic sw_reset;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // Register hit on a write strobe
  function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    wr_hit = wr && (a == ofs);
  endfunction : wr_hit

  // Zero-extend a narrow field to the data width
  function automatic logic [DATA_W-1:0] widen(input logic [Q_W-1:0] v);
    widen = DATA_W'(v);
  endfunction : widen

  // Stopped in a state where the servo is not powered
  function automatic logic is_off_state(input ssq_state_t s);
    is_off_state = (s == ST_OFF) || (s == ST_OT_OFF) || (s == ST_OT_STOP) ||
                   (s == ST_ALM_STOP) || (s == ST_ALM_HOLD);
  endfunction : is_off_state

  assign mif.sel = ssq_mode_cond_t'(q.msw[MSW_MODE_SEL_LO +: 2]); // [R9]
  assign mif.off = q.msw[MSW_MODE_OFF]; // [R8]
  assign mif.torque_ref = torque_ref_i;
  assign mif.speed_ref = speed_ref_i;
  assign mif.accel = accel_i;
  assign mif.err_count = err_count_i;
  assign mif.torque_lvl = q.trq_lvl;
  assign mif.speed_lvl = q.spd_lvl;
  assign mif.accel_lvl = q.acc_lvl;
  assign mif.err_lvl = q.err_lvl;

  ssq_mode_switch u_mode_switch (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .mif(mif)
  );

  always_comb begin
    d = q;
    overtravel = forward_travel_limit_i || reverse_travel_limit_i;
    alarm_rise = (alarm_i || power_loss_i) && !q.alarm_in;
    recovery = q.power_lost && !power_loss_i;
    auto_reset = recovery && q.msw[MSW_AUTO_RESET] && !alarm_i; // [R2]
    sw_reset = wr_hit(wr_i, addr_i, OFS_CTRL) && wdata_i[CTRL_ALARM_RESET] && !alarm_i && !power_loss_i;
    irq_set = '0;
    irq_clr = '0;

    d.alarm_in = alarm_i || power_loss_i;
    d.power_lost = power_loss_i;

    // Alarm latch: a new alarm beats any reset in the same cycle
    if (alarm_rise) begin
      d.alarm = 1'b1;
    end else if (auto_reset || sw_reset) begin
      d.alarm = 1'b0; // [R2]
    end

    // Register writes
    if (wr_hit(wr_i, addr_i, OFS_MSW)) begin
      d.msw = wdata_i;
    end
    if (wr_hit(wr_i, addr_i, OFS_TLIM)) begin
      d.tlim = wdata_i[Q_W-1:0];
    end
    if (wr_hit(wr_i, addr_i, OFS_TRQ_LVL)) begin
      d.trq_lvl = wdata_i[Q_W-1:0];
    end
    if (wr_hit(wr_i, addr_i, OFS_SPD_LVL)) begin
      d.spd_lvl = wdata_i[Q_W-1:0];
    end
    if (wr_hit(wr_i, addr_i, OFS_ACC_LVL)) begin
      d.acc_lvl = wdata_i[Q_W-1:0];
    end
    if (wr_hit(wr_i, addr_i, OFS_ERR_LVL)) begin
      d.err_lvl = wdata_i[Q_W-1:0];
    end
    if (wr_hit(wr_i, addr_i, OFS_IRQ_EN)) begin
      d.irq_en = wdata_i[IRQ_W-1:0];
    end
    if (wr_hit(wr_i, addr_i, OFS_IRQ_CLR)) begin
      irq_clr = wdata_i[IRQ_W-1:0];
    end

    // Sequencer; alarm outranks overtravel in every state
    case (q.state)
      ST_OFF: begin
        if (q.alarm) begin
          d.state = ST_ALM_STOP;
        end else if (servo_on_req_i) begin
          d.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (q.alarm) begin
          d.state = ST_ALM_STOP;
        end else if (!servo_on_req_i) begin
          d.state = ST_OFF;
        end else if (overtravel) begin
          irq_set[IRQ_OT] = 1'b1;
          d.state = q.msw[MSW_OT_DECEL] ? ST_OT_DECEL : ST_OT_STOP; // [R5]
        end
      end
      ST_OT_DECEL: begin
        if (q.alarm) begin
          d.state = ST_ALM_STOP;
        end else if (motor_stopped_i) begin
          d.state = q.msw[MSW_OT_CLAMP] ? ST_OT_CLAMP : ST_OT_OFF; // [R6]
        end
      end
      ST_OT_CLAMP, ST_OT_OFF, ST_OT_STOP: begin
        if (q.alarm) begin
          d.state = ST_ALM_STOP;
        end else if (!overtravel) begin
          d.state = servo_on_req_i ? ST_RUN : ST_OFF;
        end
      end
      ST_ALM_STOP: begin
        if (!q.alarm) begin
          d.state = ST_OFF;
        end else if (motor_stopped_i) begin
          d.state = ST_ALM_HOLD;
        end
      end
      ST_ALM_HOLD: begin
        if (!q.alarm) begin
          d.state = ST_OFF;
        end
      end
      default: begin
        d.state = ST_OFF;
      end
    endcase

    // Output decode from the next state keeps outputs flopped and aligned
    d.servo = !is_off_state(d.state);
    d.decel = d.state == ST_OT_DECEL; // [R5]
    d.clamp = d.state == ST_OT_CLAMP; // [R6]
    case (d.state)
      ST_ALM_STOP, ST_OT_STOP: begin
        d.brake = !q.msw[MSW_COAST]; // [R3]
      end
      ST_ALM_HOLD: begin
        d.brake = !q.msw[MSW_COAST] && q.msw[MSW_HOLD_BRAKE]; // [R4]
      end
      default: begin
        d.brake = 1'b0;
      end
    endcase
    d.clr_err = q.servo && !d.servo && !q.msw[MSW_KEEP_ERR]; // [R7]
    d.motion = q.msw[MSW_MOTION_SEL] ? torque_limited_i : motor_running_i; // [R1]
    d.pctrl = mif.active && d.servo; // [R11]

    // Interrupt flags: set wins over a clear in the same cycle
    irq_set[IRQ_ALARM] = alarm_rise;
    irq_set[IRQ_AUTO_RST] = auto_reset && q.alarm;
    irq_set[IRQ_MODE] = mif.changed;
    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
    d.irq = |(d.irq_stat & d.irq_en);

    // Read data stand only in the cycle after the strobe
    d.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        OFS_MSW: d.rdata = q.msw;
        OFS_TLIM: d.rdata = widen(q.tlim);
        OFS_TRQ_LVL: d.rdata = widen(q.trq_lvl);
        OFS_SPD_LVL: d.rdata = widen(q.spd_lvl);
        OFS_ACC_LVL: d.rdata = widen(q.acc_lvl);
        OFS_ERR_LVL: d.rdata = widen(q.err_lvl);
        OFS_STATUS: begin
          d.rdata[ST_STATE_LO +: 3] = q.state;
          d.rdata[ST_ALARM] = q.alarm;
          d.rdata[ST_BRAKE] = q.brake;
          d.rdata[ST_SERVO] = q.servo;
          d.rdata[ST_PCTRL] = q.pctrl;
          d.rdata[ST_OT] = overtravel;
        end
        OFS_IRQ_STAT: d.rdata[IRQ_W-1:0] = q.irq_stat;
        OFS_IRQ_EN: d.rdata[IRQ_W-1:0] = q.irq_en;
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      q <= '0;
      q.state <= ST_OFF;
      q.msw <= MSW_RESET; // [R10]
      q.tlim <= TLIM_RESET;
      q.trq_lvl <= TRQ_LVL_RESET;
      q.spd_lvl <= SPD_LVL_RESET;
      q.acc_lvl <= ACC_LVL_RESET;
      q.err_lvl <= ERR_LVL_RESET;
      q.irq_en <= IRQ_EN_RESET;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign motion_detect_output_o = q.motion;
  assign servo_enable_o = q.servo;
  assign dyn_brake_o = q.brake;
  assign torque_decel_o = q.decel;
  assign torque_limit_setting_o = q.tlim;
  assign zero_clamp_o = q.clamp;
  assign clear_error_o = q.clr_err;
  assign p_control_o = q.pctrl;
  assign irq_o = q.irq;

endmodule : ssq_sequencer

/* tb/ssq_sequencer_sva.sv */
// Port-level assertion checker for the sequencer
`timescale 1ns/100ps
module ssq_sequencer_chk (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [ssq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ssq_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ssq_pkg::DATA_W-1:0] rdata_o,
  input wire logic forward_travel_limit_i,
  input wire logic reverse_travel_limit_i,
  input wire logic motor_running_i,
  input wire logic torque_limited_i,
  input wire logic motion_detect_output_o,
  input wire logic servo_enable_o,
  input wire logic dyn_brake_o,
  input wire logic torque_decel_o,
  input wire logic zero_clamp_o,
  input wire logic clear_error_o,
  input wire logic p_control_o
);
  import ssq_pkg::*;
  logic [15:0] msw_q;
  // Shadow of the memory switch, so rules can be judged from ports alone
  always_ff @(posedge mclk_i) begin
    if (srst_i) msw_q <= MSW_RESET;
    else if (wr_i && addr_i == OFS_MSW) msw_q <= wdata_i;
  end
  default clocking dcb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  AST_MOTION: assert property (
    $past(!srst_i) |-> motion_detect_output_o == $past(msw_q[MSW_MOTION_SEL] ? torque_limited_i : motor_running_i))
    else $error("motion detect source wrong");
  AST_RD_IDLE: assert property (
    !$past(rd_i) |-> rdata_o == 16'h0000) else $error("read data outside read slot");
  AST_RD_MSW: assert property (
    $past(rd_i && addr_i == OFS_MSW) |-> rdata_o == $past(msw_q)) else $error("memory switch readback wrong");
  AST_CLR_ONE: assert property (
    clear_error_o |=> !clear_error_o) else $error("error clear longer than one cycle");
  AST_CLR_CAUSE: assert property (
    $past(!srst_i) |-> clear_error_o == ($fell(servo_enable_o) && !$past(msw_q[MSW_KEEP_ERR])))
    else $error("error clear not tied to servo off");
  AST_BRAKE: assert property (
    $rose(dyn_brake_o) |-> !$past(msw_q[MSW_COAST])) else $error("brake applied in coast mode");
  AST_DECEL: assert property (
    $rose(torque_decel_o) |-> $past(msw_q[MSW_OT_DECEL] && (forward_travel_limit_i || reverse_travel_limit_i)))
    else $error("decel without cause");
  AST_ZCLAMP: assert property (
    $rose(zero_clamp_o) |-> servo_enable_o && $past(msw_q[MSW_OT_CLAMP])) else $error("zero clamp without cause");
  AST_PCTRL: assert property (
    msw_q[MSW_MODE_OFF] [*4] |-> !p_control_o) else $error("mode switch active while disabled");
endmodule : ssq_sequencer_chk
bind ssq_sequencer ssq_sequencer_chk ssq_sequencer_chk_inst (.*);

/* tb/ssq_motor_model.sv */
// Behavioural motor: speed rises under drive, falls under brake, decel or coasting
`timescale 1ns/100ps
module ssq_motor_model (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic drive_i,
  input wire logic brake_i,
  input wire logic decel_i,
  input wire logic clamp_i,
  output logic running_o,
  output logic stopped_o,
  output logic tlim_o
);
  logic [3:0] spd_q;
  // Coasting loses one step a cycle, so stops there are the slow case
  always_ff @(posedge mclk_i) begin
    if (srst_i) spd_q <= 4'h0;
    else if (drive_i && !decel_i && !clamp_i) spd_q <= (spd_q == 4'h8) ? spd_q : spd_q + 4'h1;
    else if (spd_q != 4'h0) spd_q <= spd_q - (((brake_i || decel_i) && spd_q > 4'h1) ? 4'h2 : 4'h1);
  end
  assign running_o = spd_q != 4'h0;
  assign stopped_o = spd_q == 4'h0;
  assign tlim_o = decel_i;
endmodule : ssq_motor_model

/* tb/ssq_sequencer_tb_top.sv */
// Self-checking testbench of the sequencer
`timescale 1ns/100ps
module ssq_sequencer_tb_top;
  import ssq_pkg::*;
  typedef struct packed {logic [15:0] msw; logic [63:0] q; logic pc; logic md;} ssq_row_t;
  localparam int W_SRV = 0;
  localparam int W_BRK = 1;
  localparam int W_STP = 4;
  logic mclk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, alarm_i = 1'b0, power_loss_i = 1'b0;
  logic servo_on_req_i = 1'b0, forward_travel_limit_i = 1'b0, reverse_travel_limit_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000, torque_ref_i = 16'h0000, speed_ref_i = 16'h0000;
  logic [15:0] accel_i = 16'h0000, err_count_i = 16'h0000, rdata_o, torque_limit_setting_o;
  logic motor_running_i, torque_limited_i, motor_stopped_i, motion_detect_output_o, servo_enable_o;
  logic dyn_brake_o, torque_decel_o, zero_clamp_o, clear_error_o, p_control_o, irq_o;
  int fails = 0, n_compared = 0;
  wire logic [4:0] ob = {motor_stopped_i, zero_clamp_o, torque_decel_o, dyn_brake_o, servo_enable_o};
  // Quantity order: torque, speed, acceleration, error pulses
  ssq_row_t rows [8] = '{
    '{16'h0000, 64'h00C9_0000_0000_0000, 1'b1, 1'b1},
    '{16'h0000, 64'h00C7_FFFF_FFFF_FFFF, 1'b0, 1'b1},
    '{16'h1010, 64'hFFFF_0101_0000_0000, 1'b1, 1'b0},
    '{16'h1000, 64'hFFFF_00FF_0000_0000, 1'b0, 1'b1},
    '{16'h2000, 64'h0000_0000_0101_0000, 1'b1, 1'b1},
    '{16'h2010, 64'hFFFF_FFFF_00FF_FFFF, 1'b0, 1'b0},
    '{16'h3000, 64'h0000_0000_0000_2711, 1'b1, 1'b1},
    '{16'h3800, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0, 1'b1}};

  ssq_sequencer ssq_sequencer_inst (.*);
  ssq_motor_model ssq_motor_model_inst (.mclk_i(mclk_i), .srst_i(srst_i), .drive_i(servo_enable_o),
    .brake_i(dyn_brake_o), .decel_i(torque_decel_o), .clamp_i(zero_clamp_o), .running_o(motor_running_i),
    .stopped_o(motor_stopped_i), .tlim_o(torque_limited_i));

  always #50 mclk_i = ~mclk_i;

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc

  // Bounded wait for one watched output to reach a level
  task automatic wt(input int i, input logic v);
    int n = 0;
    #1;
    while (ob[i] !== v) begin
      @(posedge mclk_i);
      #1;
      n++;
      if (n > 80) begin
        fails++;
        $display("ERROR %0t wait on output %0d timed out", $time, i);
        close_out();
      end
    end
  endtask : wt

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd

  // Alarm from run; an early reset request must be ignored while the alarm stands
  task automatic alm(input logic [15:0] m, input logic b);
    wr(OFS_MSW, m);
    wt(W_SRV, 1'b1);
    cyc(10);
    alarm_i <= 1'b1;
    wt(W_SRV, 1'b0);
    wt(W_STP, 1'b1);
    wr(OFS_CTRL, 16'h0001);
    cyc(3);
    #1 chk(16'(dyn_brake_o), 16'(b));
    chk(16'(servo_enable_o), 16'h0000);
    @(posedge mclk_i);
    alarm_i <= 1'b0;
    wr(OFS_CTRL, 16'h0001);
    wt(W_BRK, 1'b0);
    wt(W_SRV, 1'b1);
    $display("alarm test done");
  endtask : alm

  task automatic pl(input logic [15:0] m, input logic e);
    logic [15:0] v;
    wr(OFS_MSW, m);
    power_loss_i <= 1'b1;
    wt(W_STP, 1'b1);
    @(posedge mclk_i);
    power_loss_i <= 1'b0;
    cyc(4);
    rd(OFS_STATUS, v);
    chk(16'(v[ST_ALARM]), 16'(e));
    wr(OFS_CTRL, 16'h0001);
    wt(W_SRV, 1'b1);
    $display("power loss test done");
  endtask : pl

  task automatic ot(input logic [15:0] m, input logic f, input logic d, input logic [2:0] e);
    wr(OFS_MSW, m);
    cyc(10);
    forward_travel_limit_i <= f;
    reverse_travel_limit_i <= !f;
    cyc(2);
    #1 chk(16'(torque_decel_o), 16'(d));
    wt(W_STP, 1'b1);
    cyc(2);
    #1 chk(16'({servo_enable_o, zero_clamp_o, dyn_brake_o & ~m[MSW_OT_DECEL]}), 16'(e));
    @(posedge mclk_i);
    forward_travel_limit_i <= 1'b0;
    reverse_travel_limit_i <= 1'b0;
    wt(W_SRV, 1'b1);
    $display("overtravel test done");
  endtask : ot

  initial begin
    #3000000;
    fails++;
    $display("ERROR %0t run timed out", $time);
    close_out();
  end

  initial begin
    logic [15:0] v;
    cyc(16);
    srst_i <= 1'b0;
    wr(OFS_SPD_LVL, 16'h0100);
    wr(OFS_ACC_LVL, 16'h0100);
    servo_on_req_i <= 1'b1;
    wt(W_SRV, 1'b1);
    foreach (rows[i]) begin
      wr(OFS_MSW, rows[i].msw);
      {torque_ref_i, speed_ref_i, accel_i, err_count_i} <= rows[i].q;
      cyc(6);
      #1 chk(16'(p_control_o), 16'(rows[i].pc));
      chk(16'(motion_detect_output_o), 16'(rows[i].md));
    end
    $display("mode switch table done");
    @(posedge mclk_i);
    {torque_ref_i, speed_ref_i, accel_i, err_count_i} <= 64'h0000_0000_0000_0000;
    srst_i <= 1'b1;
    cyc(2);
    srst_i <= 1'b0;
    rd(OFS_MSW, v);
    chk(v, MSW_RESET);
    rd(OFS_ERR_LVL, v);
    chk(v, ERR_LVL_RESET);
    rd(8'h3C, v);
    chk(v, 16'h0000);
    wr(OFS_TLIM, 16'h0123);
    rd(OFS_TLIM, v);
    chk(v, 16'h0123);
    chk(torque_limit_setting_o, 16'h0123);
    $display("reset test done");
    wr(OFS_IRQ_EN, 16'h0001);
    alm(16'h0080, 1'b1);
    rd(OFS_IRQ_STAT, v);
    chk(v, 16'h0001);
    chk(16'(irq_o), 16'h0001);
    wr(OFS_IRQ_EN, 16'h0000);
    cyc(2);
    #1 chk(16'(irq_o), 16'h0000);
    wr(OFS_IRQ_EN, 16'h0001);
    cyc(2);
    #1 chk(16'(irq_o), 16'h0001);
    wr(OFS_IRQ_CLR, 16'h0001);
    cyc(2);
    #1 chk(16'(irq_o), 16'h0000);
    $display("interrupt test done");
    alm(16'h0000, 1'b0);
    alm(16'h0040, 1'b0);
    pl(16'h0080, 1'b1);
    pl(16'h00A0, 1'b0);
    ot(16'h0300, 1'b1, 1'b1, 3'b110);
    ot(16'h0100, 1'b0, 1'b1, 3'b000);
    ot(16'h0000, 1'b1, 1'b0, 3'b001);
    ot(16'h0040, 1'b0, 1'b0, 3'b000);
    close_out();
  end
endmodule : ssq_sequencer_tb_top
